// ==== rtl/bpr_map.vh ====
// constants for the branch predict and retire block
`ifndef BPR_MAP_VH
`define BPR_MAP_VH
`define BPR_AW          32
`define BPR_RETIRE_MAX  2'h3
`define BPR_ISSUE_MAX   2'h3
`define BPR_CHUNK_BYTES 32'h0000_0020
`define BPR_CHUNK_MASK  32'hffff_ffe0
`define BPR_RAS_DEPTH   16
`define BPR_RAS_PW      4
`define BPR_TGT_ENTRIES 64
`define BPR_TGT_IW      6
`define BPR_TGT_LO      2
`define BPR_ROB_DEPTH   8
`define BPR_ROB_PW      3
`define BPR_TRACE_CAP   14'h3000
`define BPR_PIPE_DEPTH  5'h14
`define BPR_INSN_LEN    32'h0000_0004
`define BPR_CTR_INIT    2'h1
`define BPR_CTR_TAKEN   1
// branch kinds
`define BPR_K_NONE      3'h0
`define BPR_K_COND      3'h1
`define BPR_K_JMP       3'h2
`define BPR_K_CALL      3'h3
`define BPR_K_RET       3'h4
`define BPR_K_IND       3'h5
`define BPR_K_FAR       3'h6
// hint codes
`define BPR_H_NONE      2'h0
`define BPR_H_TAKEN     2'h1
`define BPR_H_NOT       2'h2
// front end states
`define BPR_S_RUN       1'b0
`define BPR_S_PEN       1'b1
`endif

// ==== rtl/bpr_core.v ====
// branch prediction front end and in-order retirement control
`timescale 1ns/1ps
`include "bpr_map.vh"
// Functional notes
// - a micro-op retires once completed and its result written
// - at most three micro-ops retire per clock
// - architectural updates commit strictly in program order
// - exceptions raised only at retirement of the faulting op
// - commit buffer holds completed ops, commits in order, orders exceptions
// - retired branch sends resolved target to the target store
// - fetch follows predicted path in 32-byte chunks from target
// - one decoder, at most one instruction per clock
// - complex instructions are expanded by microcode sequence
// - trace store holds up to 12K ops, supplies three per cycle
// - correctly predicted branch costs zero penalty cycles
// - mispredict costs about pipeline depth cycles
// - all near branch kinds are predicted; indirect ones only on a target store hit
// - far transfers are never predicted
// - dynamic lookup uses linear address before decode
// - static fallback: backward conditional taken, forward not taken
// - sixteen-entry return stack, push on call, pop on return
// - trace building continues across predicted-taken branches
// - hint prefixes on conditionals guide prediction and trace build
// - hints used only while building, not for stored traces
// - directional hint overrides static prediction
module bpr_core (
    input  wire        ref_clk_in,
    input  wire        rst_in,
    // fetch request toward memory
    input  wire        fetch_ready_in,
    output reg         fetch_valid_out,
    output reg  [31:0] fetch_addr_out,
    // decoder input: one instruction per clock
    input  wire        dec_valid_in,
    input  wire [31:0] dec_addr_in,
    input  wire [2:0]  dec_kind_in,
    input  wire [31:0] dec_disp_in,
    input  wire [1:0]  dec_hint_in,
    input  wire        dec_complex_in,
    input  wire        dec_building_in,
    output reg         dec_taken_out,
    output reg  [31:0] dec_target_out,
    output reg         dec_ucode_out,
    output reg         dec_trace_cont_out,
    output reg         dec_ready_out,
    // trace store delivery
    input  wire [1:0]  trace_count_in,
    input  wire [13:0] trace_fill_in,
    output reg  [1:0]  issue_count_out,
    // completion from the execution core
    input  wire        cpl_valid_in,
    input  wire [2:0]  cpl_tag_in,
    input  wire        cpl_exc_in,
    input  wire        cpl_branch_in,
    input  wire        cpl_mispred_in,
    input  wire [31:0] cpl_pc_in,
    input  wire [31:0] cpl_target_in,
    input  wire        cpl_taken_in,
    input  wire        alloc_in,
    output reg  [2:0]  alloc_tag_out,
    output reg         alloc_ready_out,
    // retirement results
    output reg  [1:0]  retire_count_out,
    output reg         exc_out,
    output reg  [31:0] exc_pc_out,
    output reg         flush_out,
    output reg         tgt_upd_valid_out,
    output reg  [31:0] tgt_upd_pc_out,
    output reg  [31:0] tgt_upd_target_out
);
    reg  [`BPR_TGT_ENTRIES-1:0] tgt_valid_reg;
    reg  [31:0] tgt_addr_reg [0:`BPR_TGT_ENTRIES-1];
    reg  [1:0]  tgt_ctr_reg  [0:`BPR_TGT_ENTRIES-1];
    reg  [31:0] ras_reg [0:`BPR_RAS_DEPTH-1];
    reg  [`BPR_RAS_PW-1:0]   ras_ptr_reg;
    reg  [`BPR_ROB_DEPTH-1:0] rob_done_reg;
    reg  [`BPR_ROB_DEPTH-1:0] rob_exc_reg;
    reg  [`BPR_ROB_DEPTH-1:0] rob_br_reg;
    reg  [`BPR_ROB_DEPTH-1:0] rob_mis_reg;
    reg  [`BPR_ROB_DEPTH-1:0] rob_tk_reg;
    reg  [31:0] rob_pc_reg  [0:`BPR_ROB_DEPTH-1];
    reg  [31:0] rob_tgt_reg [0:`BPR_ROB_DEPTH-1];
    reg  [`BPR_ROB_PW:0]     rob_cnt_reg;
    reg  [`BPR_ROB_PW-1:0]   rob_head_reg;
    reg  [`BPR_ROB_PW-1:0]   rob_tail_reg;
    reg                      state_reg;
    reg  [4:0]               pen_cnt_reg;
    reg  [31:0]              redirect_reg;
    // synchronisers are not needed: all inputs come from same-clock logic
    wire [`BPR_TGT_IW-1:0] dec_idx = dec_addr_in[`BPR_TGT_LO+`BPR_TGT_IW-1:`BPR_TGT_LO];
    wire [`BPR_TGT_IW-1:0] fet_idx =
        fetch_addr_out[`BPR_TGT_LO+`BPR_TGT_IW-1:`BPR_TGT_LO];
    wire [`BPR_TGT_IW-1:0] upd_idx =
        tgt_upd_pc_out[`BPR_TGT_LO+`BPR_TGT_IW-1:`BPR_TGT_LO];
    wire running = (state_reg == `BPR_S_RUN);

    // prediction at decode
    reg        pred_taken;
    reg [31:0] pred_target;
    reg        dyn_hit;
    wire [31:0] fall_through = dec_addr_in + `BPR_INSN_LEN;
    wire [31:0] disp_target  = dec_addr_in + dec_disp_in;
    wire [`BPR_RAS_PW-1:0] ras_top = ras_ptr_reg - 4'h1;
    always @* begin
        dyn_hit     = tgt_valid_reg[dec_idx];
        pred_taken  = 1'b0;
        pred_target = fall_through;
        case (dec_kind_in)
            `BPR_K_COND: begin
                if (dyn_hit) begin
                    pred_taken  = tgt_ctr_reg[dec_idx][`BPR_CTR_TAKEN];
                    pred_target = tgt_addr_reg[dec_idx];
                end else if (dec_building_in && dec_hint_in != `BPR_H_NONE) begin
                    pred_taken  = (dec_hint_in == `BPR_H_TAKEN);
                    pred_target = disp_target;
                end else begin
                    pred_taken  = dec_disp_in[31];
                    pred_target = disp_target;
                end
            end
            `BPR_K_JMP, `BPR_K_CALL: begin
                pred_taken  = 1'b1;
                pred_target = dyn_hit ? tgt_addr_reg[dec_idx] : disp_target;
            end
            `BPR_K_RET: begin
                pred_taken  = 1'b1;
                pred_target = ras_reg[ras_top];
            end
            `BPR_K_IND: begin
                pred_taken  = dyn_hit;
                pred_target = dyn_hit ? tgt_addr_reg[dec_idx] : fall_through;
            end
            default: begin
                pred_taken  = 1'b0;
                pred_target = fall_through;
            end
        endcase
    end

    // commit buffer head window, up to three in order
    reg [1:0]  ret_n;
    reg        ret_exc;
    reg [31:0] ret_exc_pc;
    reg        ret_br;
    reg        ret_mis;
    reg [31:0] ret_pc;
    reg [31:0] ret_tgt;
    reg        ret_tk;
    reg        stop;
    reg [`BPR_ROB_PW-1:0] ix;
    integer k;
    always @* begin
        ret_n = 2'h0;
        ret_exc = 1'b0;
        ret_exc_pc = 32'h0;
        ret_br = 1'b0;
        ret_mis = 1'b0;
        ret_pc = 32'h0;
        ret_tgt = 32'h0;
        ret_tk = 1'b0;
        stop = 1'b0;
        ix = rob_head_reg;
        for (k = 0; k < 3; k = k + 1) begin
            ix = rob_head_reg + k[`BPR_ROB_PW-1:0];
            if (!stop && (k < rob_cnt_reg) && rob_done_reg[ix]) begin
                ret_n = ret_n + 2'h1;
                if (rob_br_reg[ix]) begin
                    ret_br = 1'b1;
                    ret_pc = rob_pc_reg[ix];
                    ret_tgt = rob_tgt_reg[ix];
                    ret_tk = rob_tk_reg[ix];
                end
                if (rob_exc_reg[ix]) begin
                    ret_exc = 1'b1;
                    ret_exc_pc = rob_pc_reg[ix];
                    stop = 1'b1;
                end else if (rob_mis_reg[ix]) begin
                    ret_mis = 1'b1;
                    stop = 1'b1;
                end else if (rob_br_reg[ix]) begin
                    stop = 1'b1;
                end
            end else begin
                stop = 1'b1;
            end
        end
    end

    wire flush_now = ret_exc | ret_mis;
    wire do_alloc  = alloc_in && alloc_ready_out && !flush_now;
    wire dec_go    = dec_valid_in && dec_ready_out;
    wire [`BPR_TGT_IW-1:0] ret_idx = ret_pc[`BPR_TGT_LO+`BPR_TGT_IW-1:`BPR_TGT_LO];
    integer j;
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            fetch_valid_out <= 1'b0;
            fetch_addr_out <= 32'h0;
            dec_taken_out <= 1'b0;
            dec_target_out <= 32'h0;
            dec_ucode_out <= 1'b0;
            dec_trace_cont_out <= 1'b0;
            dec_ready_out <= 1'b0;
            issue_count_out <= 2'h0;
            alloc_tag_out <= {`BPR_ROB_PW{1'b0}};
            alloc_ready_out <= 1'b0;
            retire_count_out <= 2'h0;
            exc_out <= 1'b0;
            exc_pc_out <= 32'h0;
            flush_out <= 1'b0;
            tgt_upd_valid_out <= 1'b0;
            tgt_upd_pc_out <= 32'h0;
            tgt_upd_target_out <= 32'h0;
            tgt_valid_reg <= {`BPR_TGT_ENTRIES{1'b0}};
            ras_ptr_reg <= 4'h0;
            rob_done_reg <= 8'h0;
            rob_exc_reg <= 8'h0;
            rob_br_reg <= 8'h0;
            rob_mis_reg <= 8'h0;
            rob_tk_reg <= 8'h0;
            rob_cnt_reg <= 4'h0;
            rob_head_reg <= 3'h0;
            rob_tail_reg <= 3'h0;
            state_reg <= `BPR_S_RUN;
            pen_cnt_reg <= 5'h0;
            redirect_reg <= 32'h0;
        end else begin
            // fetcher: chunk-aligned stream along predicted path
            fetch_valid_out <= running;
            if (flush_now) begin
                redirect_reg <= ret_exc ? ret_exc_pc : ret_tgt;
                state_reg <= `BPR_S_PEN;
                pen_cnt_reg <= `BPR_PIPE_DEPTH;
                fetch_valid_out <= 1'b0;
            end else if (state_reg == `BPR_S_PEN) begin
                fetch_valid_out <= 1'b0;
                if (pen_cnt_reg == 5'h1) begin
                    state_reg <= `BPR_S_RUN;
                    fetch_addr_out <= redirect_reg & `BPR_CHUNK_MASK;
                    fetch_valid_out <= 1'b1;
                end
                pen_cnt_reg <= pen_cnt_reg - 5'h1;
            end else if (dec_go && pred_taken) begin
                fetch_addr_out <= pred_target & `BPR_CHUNK_MASK;
            end else if (fetch_valid_out && fetch_ready_in) begin
                fetch_addr_out <= (fetch_addr_out & `BPR_CHUNK_MASK) + `BPR_CHUNK_BYTES;
            end
            // dynamic lookup ahead of decode on the fetch address
            if (running && fetch_valid_out && tgt_valid_reg[fet_idx] && !dec_go
                && tgt_ctr_reg[fet_idx][`BPR_CTR_TAKEN] && fetch_ready_in)
                fetch_addr_out <= tgt_addr_reg[fet_idx] & `BPR_CHUNK_MASK;
            // decoder: one instruction per clock
            dec_ready_out <= running && !flush_now;
            dec_taken_out <= dec_go && pred_taken;
            dec_target_out <= pred_target;
            dec_ucode_out <= dec_go && dec_complex_in;
            dec_trace_cont_out <= dec_go && dec_building_in && pred_taken;
            if (dec_go && dec_kind_in == `BPR_K_CALL) begin
                ras_reg[ras_ptr_reg] <= fall_through;
                ras_ptr_reg <= ras_ptr_reg + 4'h1;
            end else if (dec_go && dec_kind_in == `BPR_K_RET) begin
                ras_ptr_reg <= ras_top;
            end
            // trace store delivery capped at three per cycle
            issue_count_out <= (running && trace_fill_in <= `BPR_TRACE_CAP
                && trace_count_in <= `BPR_ISSUE_MAX) ? trace_count_in : 2'h0;
            // commit buffer bookkeeping
            if (do_alloc) begin
                alloc_tag_out <= rob_tail_reg + 3'h1;
                rob_tail_reg <= rob_tail_reg + 3'h1;
                rob_done_reg[rob_tail_reg] <= 1'b0;
            end
            if (cpl_valid_in) begin
                rob_done_reg[cpl_tag_in] <= 1'b1;
                rob_exc_reg[cpl_tag_in] <= cpl_exc_in;
                rob_br_reg[cpl_tag_in] <= cpl_branch_in;
                rob_mis_reg[cpl_tag_in] <= cpl_mispred_in;
                rob_tk_reg[cpl_tag_in] <= cpl_taken_in;
                rob_pc_reg[cpl_tag_in] <= cpl_pc_in;
                rob_tgt_reg[cpl_tag_in] <= cpl_target_in;
            end
            for (j = 0; j < 3; j = j + 1)
                if (j < ret_n)
                    rob_done_reg[rob_head_reg + j[`BPR_ROB_PW-1:0]] <= 1'b0;
            if (flush_now) begin
                rob_done_reg <= 8'h0;
                rob_cnt_reg <= 4'h0;
                rob_head_reg <= 3'h0;
                rob_tail_reg <= 3'h0;
                alloc_tag_out <= 3'h0;
            end else begin
                rob_head_reg <= rob_head_reg + {1'b0, ret_n};
                rob_cnt_reg <= rob_cnt_reg + {3'h0, do_alloc} - {2'h0, ret_n};
            end
            alloc_ready_out <= !flush_now && (rob_cnt_reg + {3'h0, do_alloc}
                < `BPR_ROB_DEPTH - 1);
            retire_count_out <= ret_n;
            exc_out <= ret_exc;
            exc_pc_out <= ret_exc_pc;
            flush_out <= flush_now;
            // target store update on retired branch
            tgt_upd_valid_out <= ret_br;
            tgt_upd_pc_out <= ret_pc;
            tgt_upd_target_out <= ret_tgt;
            if (tgt_upd_valid_out) begin
                tgt_valid_reg[upd_idx] <= 1'b1;
                tgt_addr_reg[upd_idx] <= tgt_upd_target_out;
            end
            if (ret_br) begin
                if (!tgt_valid_reg[ret_idx])
                    tgt_ctr_reg[ret_idx] <= ret_tk ? 2'h2 : `BPR_CTR_INIT;
                else if (ret_tk && tgt_ctr_reg[ret_idx] != 2'h3)
                    tgt_ctr_reg[ret_idx] <= tgt_ctr_reg[ret_idx] + 2'h1;
                else if (!ret_tk && tgt_ctr_reg[ret_idx] != 2'h0)
                    tgt_ctr_reg[ret_idx] <= tgt_ctr_reg[ret_idx] - 2'h1;
            end
        end
    end
endmodule // bpr_core

// ==== testbench/bpr_core_assertions.sv ====
// assertion checker bound to the branch predict and retire core
`timescale 1ns/1ps
`include "bpr_map.vh"
module bpr_core_assertions (
    input wire        ref_clk_in,
    input wire        rst_in,
    input wire        fetch_ready_in,
    input wire        fetch_valid_out,
    input wire [31:0] fetch_addr_out,
    input wire        dec_valid_in,
    input wire [2:0]  dec_kind_in,
    input wire        dec_complex_in,
    input wire        dec_ready_out,
    input wire        dec_taken_out,
    input wire        dec_ucode_out,
    input wire        alloc_ready_out,
    input wire [1:0]  retire_count_out,
    input wire        exc_out,
    input wire        flush_out,
    input wire        tgt_upd_valid_out
);
    wire take = dec_valid_in && dec_ready_out;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    a_fetch_aligned: assert property (fetch_valid_out |-> fetch_addr_out[4:0] == 5'h00)
        else $error("fetch address not chunk aligned");
    a_fetch_held: assert property (fetch_valid_out && !fetch_ready_in |=>
        (fetch_valid_out && $stable(fetch_addr_out)) || flush_out) else $error("fetch dropped");
    a_flush_fetch_idle: assert property ($rose(flush_out) |=> !fetch_valid_out [*8])
        else $error("fetch resumed too soon after flush");
    a_redirect_bound: assert property ($rose(flush_out) |-> ##[1:60] fetch_valid_out)
        else $error("no redirect fetch after flush");
    a_ucode_pulse: assert property (take && dec_complex_in |=> dec_ucode_out)
        else $error("complex instruction not sent to microcode");
    a_far_unpredicted: assert property (take && dec_kind_in == `BPR_K_FAR |=> !dec_taken_out)
        else $error("far transfer predicted taken");
    a_exc_with_flush: assert property (exc_out |-> flush_out && !fetch_valid_out)
        else $error("exception without flush");
    a_update_at_retire: assert property (tgt_upd_valid_out |->
        retire_count_out != 2'h0 || $past(retire_count_out) != 2'h0) else $error("update unretired");
    a_reset_quiet: assert property ($past(rst_in) |-> retire_count_out == 2'h0
        && !alloc_ready_out && !dec_ready_out) else $error("outputs active after reset");
    c_retire_three: cover property (retire_count_out == 2'h3);
    c_flush: cover property ($rose(flush_out));
    c_ucode: cover property (dec_ucode_out);
endmodule // bpr_core_assertions
bind bpr_core bpr_core_assertions u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .fetch_ready_in(fetch_ready_in), .fetch_valid_out(fetch_valid_out),
    .fetch_addr_out(fetch_addr_out), .dec_valid_in(dec_valid_in), .dec_kind_in(dec_kind_in),
    .dec_complex_in(dec_complex_in), .dec_ready_out(dec_ready_out),
    .dec_taken_out(dec_taken_out), .dec_ucode_out(dec_ucode_out),
    .alloc_ready_out(alloc_ready_out), .retire_count_out(retire_count_out), .exc_out(exc_out),
    .flush_out(flush_out), .tgt_upd_valid_out(tgt_upd_valid_out));

// ==== testbench/bpr_exec_model.sv ====
// execution core and memory model: fetch acceptance and out-of-order completion
`timescale 1ns/1ps
module bpr_exec_model (
    input  wire        ref_clk_in,
    input  wire        rst_in,
    input  wire        slow_in,
    input  wire        alloc_fire_in,
    input  wire [2:0]  alloc_tag_in,
    input  wire        go_in,
    input  wire [3:0]  exc_tag_in,
    input  wire [3:0]  br_tag_in,
    input  wire        mis_in,
    output reg         fetch_ready_out,
    output reg         cpl_valid_out,
    output reg  [2:0]  cpl_tag_out,
    output reg         cpl_exc_out,
    output reg         cpl_branch_out,
    output reg         cpl_mispred_out,
    output reg  [31:0] cpl_pc_out,
    output reg  [31:0] cpl_target_out,
    output reg         cpl_taken_out
);
    reg [2:0] tags [0:7];
    reg [3:0] cnt  = 4'h0;
    reg [3:0] ptr  = 4'h0;
    reg [1:0] tick = 2'h0;
    reg       run  = 1'b0;
    reg [2:0] t;
    initial {fetch_ready_out, cpl_valid_out, cpl_tag_out, cpl_exc_out, cpl_branch_out} = 0;
    initial {cpl_mispred_out, cpl_pc_out, cpl_target_out, cpl_taken_out} = 0;
    always @(posedge ref_clk_in) begin
        run <= go_in && !rst_in;
        if (rst_in)
            cnt <= 4'h0;
        else if (alloc_fire_in) begin
            tags[cnt[2:0]] <= alloc_tag_in;
            cnt <= cnt + 4'h1;
        end
    end
    // youngest completes first, so the commit buffer has to reorder
    always @(negedge ref_clk_in) begin
        tick = tick + 2'h1;
        fetch_ready_out = !slow_in || tick == 2'h0;
        cpl_valid_out = 1'b0;
        cpl_pc_out = ~cpl_pc_out;
        cpl_target_out = ~cpl_target_out;
        if (!run)
            ptr = 4'h0;
        else if (ptr < cnt && (!slow_in || tick[0])) begin
            t = tags[cnt[2:0] - 3'h1 - ptr[2:0]];
            ptr = ptr + 4'h1;
            cpl_valid_out = 1'b1;
            cpl_tag_out = t;
            cpl_exc_out = exc_tag_in == {1'b0, t};
            cpl_branch_out = br_tag_in == {1'b0, t};
            cpl_mispred_out = mis_in && br_tag_in == {1'b0, t};
            cpl_pc_out = 32'h0000_1000 | {27'h0, t, 2'h0};
            cpl_target_out = 32'h0000_2046 + {24'h0, t, 5'h00};
            cpl_taken_out = 1'b1;
        end
    end
endmodule // bpr_exec_model

// ==== testbench/bpr_core_tb.sv ====
// self-checking bench for the branch predict and retire core
`timescale 1ns/1ps
`include "bpr_map.vh"
module bpr_core_tb;
    reg ref_clk_in = 0, rst_in = 1, dec_valid_in = 0, dec_complex_in = 0, dec_building_in = 0;
    reg [31:0] dec_addr_in = 0, dec_disp_in = 0, ca, rnd;
    reg [2:0] dec_kind_in = 0;
    reg [1:0] dec_hint_in = 0, trace_count_in = 0;
    reg [13:0] trace_fill_in = 0;
    reg alloc_in = 0, slow = 0, go = 0, mis = 0, es;
    reg [3:0] exc_tag = 4'h8, br_tag = 4'h8;
    reg [7:0] done = 0, stopf = 0, flushf = 0;
    integer seed = 13438, bad_count = 0, total_checks = 0, cyc = 0, head, n, k, w, idle, acc;
    integer exp_ret = 0;
    wire fetch_ready_in, fetch_valid_out, dec_taken_out, dec_ucode_out, dec_trace_cont_out;
    wire dec_ready_out, cpl_valid_in, cpl_exc_in, cpl_branch_in, cpl_mispred_in, cpl_taken_in;
    wire alloc_ready_out, exc_out, flush_out, tgt_upd_valid_out;
    wire [31:0] fetch_addr_out, dec_target_out, cpl_pc_in, cpl_target_in, exc_pc_out;
    wire [31:0] tgt_upd_pc_out, tgt_upd_target_out;
    wire [2:0] cpl_tag_in, alloc_tag_out;
    wire [1:0] issue_count_out, retire_count_out;
    bpr_core uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .fetch_ready_in(fetch_ready_in),
        .fetch_valid_out(fetch_valid_out), .fetch_addr_out(fetch_addr_out),
        .dec_valid_in(dec_valid_in), .dec_addr_in(dec_addr_in), .dec_kind_in(dec_kind_in),
        .dec_disp_in(dec_disp_in), .dec_hint_in(dec_hint_in), .dec_complex_in(dec_complex_in),
        .dec_building_in(dec_building_in), .dec_taken_out(dec_taken_out),
        .dec_target_out(dec_target_out), .dec_ucode_out(dec_ucode_out),
        .dec_trace_cont_out(dec_trace_cont_out), .dec_ready_out(dec_ready_out),
        .trace_count_in(trace_count_in), .trace_fill_in(trace_fill_in),
        .issue_count_out(issue_count_out), .cpl_valid_in(cpl_valid_in), .cpl_tag_in(cpl_tag_in),
        .cpl_exc_in(cpl_exc_in), .cpl_branch_in(cpl_branch_in), .cpl_mispred_in(cpl_mispred_in),
        .cpl_pc_in(cpl_pc_in), .cpl_target_in(cpl_target_in), .cpl_taken_in(cpl_taken_in),
        .alloc_in(alloc_in), .alloc_tag_out(alloc_tag_out), .alloc_ready_out(alloc_ready_out),
        .retire_count_out(retire_count_out), .exc_out(exc_out), .exc_pc_out(exc_pc_out),
        .flush_out(flush_out), .tgt_upd_valid_out(tgt_upd_valid_out),
        .tgt_upd_pc_out(tgt_upd_pc_out), .tgt_upd_target_out(tgt_upd_target_out));
    bpr_exec_model partner (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .slow_in(slow),
        .alloc_fire_in(alloc_in && alloc_ready_out), .alloc_tag_in(alloc_tag_out), .go_in(go),
        .exc_tag_in(exc_tag), .br_tag_in(br_tag), .mis_in(mis), .fetch_ready_out(fetch_ready_in),
        .cpl_valid_out(cpl_valid_in), .cpl_tag_out(cpl_tag_in), .cpl_exc_out(cpl_exc_in),
        .cpl_branch_out(cpl_branch_in), .cpl_mispred_out(cpl_mispred_in),
        .cpl_pc_out(cpl_pc_in), .cpl_target_out(cpl_target_in), .cpl_taken_out(cpl_taken_in));
    always #5 ref_clk_in = ~ref_clk_in;
    task check(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    always @(posedge ref_clk_in) begin
        cyc = cyc + 1;
        if (cyc > 20000) begin
            bad_count = bad_count + 1;
            end_of_test;
        end
    end
    // in-order commit model: up to three, stop after a flagged op
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            head = 0;
            done = 0;
            exp_ret = 0;
        end else begin
            n = 0;
            k = 0;
            while (n < 3 && k == 0 && done[(head + n) % 8]) begin
                done[(head + n) % 8] = 1'b0;
                k = flushf[(head + n) % 8] ? 2 : stopf[(head + n) % 8];
                n = n + 1;
            end
            head = (head + n) % 8;
            exp_ret = n;
            if (k == 2) begin
                done = 0;
                head = 0;
            end
            if (cpl_valid_in) begin
                done[cpl_tag_in] = 1'b1;
                stopf[cpl_tag_in] = cpl_branch_in | cpl_exc_in | cpl_mispred_in;
                flushf[cpl_tag_in] = cpl_exc_in | cpl_mispred_in;
            end
        end
    end
    always @(negedge ref_clk_in) if (!rst_in) check(retire_count_out, exp_ret);
    task dec(input [2:0] kd, input [31:0] dp, input [1:0] ht, input bld, input cx, input et);
        begin
            @(negedge ref_clk_in);
            {dec_valid_in, dec_kind_in, dec_disp_in, dec_hint_in} = {1'b1, kd, dp, ht};
            {dec_building_in, dec_complex_in} = {bld, cx};
            dec_addr_in = $random(seed) & 32'hffff_fffc;
            rnd = $random(seed);
            {trace_fill_in, trace_count_in} = rnd[15:0];
            w = 0;
            @(posedge ref_clk_in);
            while (!dec_ready_out && w < 20) begin
                w = w + 1;
                @(posedge ref_clk_in);
            end
            @(negedge ref_clk_in);
            dec_valid_in = 1'b0;
            check(dec_taken_out, et);
            check(dec_trace_cont_out, et & bld);
            check(dec_ucode_out, cx);
            if (trace_fill_in > `BPR_TRACE_CAP)
                check(issue_count_out, 0);
            else
                check(issue_count_out, trace_count_in);
            if (et && kd != `BPR_K_RET)
                check(fetch_addr_out, (dec_addr_in + dp) & `BPR_CHUNK_MASK);
        end
    endtask
    task session(input integer cnt, input [3:0] et, input [3:0] bt, input m, input s);
        begin
            {exc_tag, br_tag, mis, slow, go, rst_in} = {et, bt, m, s, 1'b0, 1'b1};
            repeat (5) @(negedge ref_clk_in);
            rst_in = 1'b0;
            repeat (2) @(negedge ref_clk_in);
            {acc, w, alloc_in} = {32'h0, 32'h0, cnt != 0};
            while (acc < cnt && w < 50) begin
                @(posedge ref_clk_in);
                w = w + 1;
                if (alloc_ready_out)
                    acc = acc + 1;
            end
            @(negedge ref_clk_in);
            alloc_in = 1'b0;
            check(alloc_tag_out, cnt % 8);
            if (cnt == 7)
                check(alloc_ready_out, 0);
            go = 1'b1;
        end
    endtask
    task step;
        begin
            @(negedge ref_clk_in);
            if (exc_out) begin
                es = 1'b1;
                check(exc_pc_out, 32'h0000_1004);
            end
        end
    endtask
    task redirect(input [31:0] addr, input e);
        begin
            {es, w, idle} = {1'b0, 32'h0, 32'h0};
            while (!flush_out && w < 100) begin
                step;
                w = w + 1;
            end
            step;
            while (!fetch_valid_out && idle < 100) begin
                step;
                idle = idle + 1;
            end
            check(es, e);
            check(idle >= 16, 1);
            check(fetch_addr_out, addr & `BPR_CHUNK_MASK);
        end
    endtask
    initial begin
        session(0, 4'h8, 4'h8, 0, 0);
        dec(`BPR_K_COND, -32'sd16, `BPR_H_NONE, 0, 0, 1);
        dec(`BPR_K_COND, 32'h10, `BPR_H_NONE, 0, 0, 0);
        dec(`BPR_K_COND, 32'h10, `BPR_H_TAKEN, 1, 0, 1);
        dec(`BPR_K_COND, 32'h10, `BPR_H_TAKEN, 0, 0, 0);
        dec(`BPR_K_COND, -32'sd16, `BPR_H_NOT, 1, 0, 0);
        dec(`BPR_K_JMP, -32'sd64, `BPR_H_NONE, 1, 0, 1);
        dec(`BPR_K_IND, -32'sd64, `BPR_H_NONE, 0, 0, 0);
        dec(`BPR_K_FAR, -32'sd64, `BPR_H_NONE, 0, 0, 0);
        dec(`BPR_K_NONE, 32'h0, `BPR_H_NONE, 0, 1, 0);
        dec(`BPR_K_CALL, -32'sd64, `BPR_H_NONE, 0, 0, 1);
        ca = dec_addr_in;
        dec(`BPR_K_RET, -32'sd64, `BPR_H_NONE, 0, 0, 1);
        check(dec_target_out, ca + `BPR_INSN_LEN);
        session(7, 4'h8, 4'h2, 0, 0);
        w = 0;
        while (!tgt_upd_valid_out && w < 60) begin
            @(negedge ref_clk_in);
            w = w + 1;
        end
        check(tgt_upd_pc_out, 32'h0000_1008);
        check(tgt_upd_target_out, 32'h0000_2086);
        repeat (10) @(negedge ref_clk_in);
        check(alloc_ready_out, 1);
        session(4, 4'h1, 4'h8, 0, 1);
        redirect(32'h0000_1004, 1'b1);
        session(3, 4'h8, 4'h0, 1, 0);
        redirect(32'h0000_2046, 1'b0);
        repeat (10) @(negedge ref_clk_in);
        end_of_test;
    end
endmodule // bpr_core_tb
